/* File: include/counter_data_ports_regs.svh */
`ifndef COUNTER_DATA_PORTS_REGS_SVH
`define COUNTER_DATA_PORTS_REGS_SVH

// byte offsets on the register port
`define CDP_CNT_ONE_OFS 8'h18
`define CDP_CNT_TWO_OFS 8'h1a
`define CDP_CMD_OFS 8'h1e

// command byte fields
`define CDP_SEL_HI 7
`define CDP_SEL_LO 6
`define CDP_ACC_HI 5
`define CDP_ACC_LO 4
`define CDP_CTRL_HI 5

// counter select encodings
`define CDP_SEL_ONE 2'h0
`define CDP_SEL_TWO 2'h1
`define CDP_SEL_THREE 2'h2
`define CDP_SEL_READBACK 2'h3

// byte access encodings
`define CDP_ACC_LATCH 2'h0
`define CDP_ACC_LOW 2'h1
`define CDP_ACC_HIGH 2'h2
`define CDP_ACC_BOTH 2'h3

// read-back command bits, count and status flags are active low
`define CDP_RB_NCOUNT_BIT 5
`define CDP_RB_NSTATUS_BIT 4
`define CDP_RB_ONE_BIT 1
`define CDP_RB_TWO_BIT 2

// reset values
`define CDP_CTRL_RST 6'h30
`define CDP_BYTE_RST 8'h00
`define CDP_COUNT_RST 16'h0000

`endif

/* File: include/counter_data_ports_pkg.sv */
package counter_data_ports_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] count_t;
    typedef logic [5:0] ctrl_t;
    typedef logic [1:0] field_t;

    // which byte of a two-byte transfer comes next
    typedef enum logic [1:0] {
        PTR_LOW = 2'b01,
        PTR_HIGH = 2'b10
    } byte_ptr_t;

endpackage

/* File: core/counter_data_ports.sv */
// Function
// - data port write loads counter start value
// - nothing latched: read returns live count
// - latched count or status read instead
// - latched data held until read out
// - only first status and count capture kept
// - latched 16-bit count: low then high
// - status first, then count bytes follow
// - byte-wide ports, 16 bits take two accesses
// - ports at offsets 18 and 1A hex
// - select field: counters 1,2,3, read-back
// - access field: latch, low, high, both
`timescale 1ns/10ps
`default_nettype none
`include "counter_data_ports_regs.svh"

module counter_data_ports (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] count_one_live,
    input wire logic count_one_out,
    input wire logic count_one_null,
    output logic [15:0] count_one_load_value,
    output logic count_one_load_pulse,
    output logic [5:0] count_one_ctrl,
    input wire logic [15:0] count_two_live,
    input wire logic count_two_out,
    input wire logic count_two_null,
    output logic [15:0] count_two_load_value,
    output logic count_two_load_pulse,
    output logic [5:0] count_two_ctrl
);

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    // reset is asserted at once and released only after two edges
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    function automatic logic [7:0] port_ofs(input int idx);
        port_ofs = (idx == 0) ? `CDP_CNT_ONE_OFS : `CDP_CNT_TWO_OFS;
    endfunction

    function automatic logic [1:0] sel_code(input int idx);
        sel_code = (idx == 0) ? `CDP_SEL_ONE : `CDP_SEL_TWO;
    endfunction

    function automatic logic rb_pick(input logic [7:0] cmd, input int idx);
        rb_pick = (idx == 0) ? cmd[`CDP_RB_ONE_BIT] : cmd[`CDP_RB_TWO_BIT];
    endfunction

    wire logic cmd_wr;
    wire logic [1:0] cmd_sel;
    wire logic [1:0] cmd_acc;
    wire logic cmd_readback;

    assign cmd_wr = reg_wr && (reg_addr == `CDP_CMD_OFS);
    assign cmd_sel = reg_wdata[`CDP_SEL_HI:`CDP_SEL_LO];
    assign cmd_acc = reg_wdata[`CDP_ACC_HI:`CDP_ACC_LO];
    // counter three and its commands belong to another block
    assign cmd_readback = cmd_sel == `CDP_SEL_READBACK;

    wire logic [15:0] live_in [2];
    wire logic out_in [2];
    wire logic null_in [2];
    wire logic [7:0] rd_byte [2];
    wire logic data_rd [2];

    assign live_in[0] = count_one_live;
    assign live_in[1] = count_two_live;
    assign out_in[0] = count_one_out;
    assign out_in[1] = count_two_out;
    assign null_in[0] = count_one_null;
    assign null_in[1] = count_two_null;

    for (genvar i = 0; i < 2; i++) begin : gen_cnt
        counter_data_ports_pkg::ctrl_t ctrl_ff;
        counter_data_ports_pkg::byte_ptr_t ptr_ff;
        counter_data_ports_pkg::count_t hold_cnt_ff;
        counter_data_ports_pkg::byte_t hold_st_ff;
        counter_data_ports_pkg::byte_t low_buf_ff;
        counter_data_ports_pkg::count_t load_ff;
        logic cnt_held_ff;
        logic st_held_ff;
        logic load_pulse_ff;

        counter_data_ports_pkg::ctrl_t nxt_ctrl;
        counter_data_ports_pkg::byte_ptr_t nxt_ptr;
        counter_data_ports_pkg::count_t nxt_hold_cnt;
        counter_data_ports_pkg::byte_t nxt_hold_st;
        counter_data_ports_pkg::byte_t nxt_low_buf;
        counter_data_ports_pkg::count_t nxt_load;
        logic nxt_cnt_held;
        logic nxt_st_held;
        logic nxt_load_pulse;

        wire logic port_hit;
        wire logic data_wr;
        wire logic mode_wr;
        wire logic cnt_cap;
        wire logic st_cap;
        wire logic [1:0] acc;
        wire logic take_high;
        wire logic last_byte;
        wire logic [7:0] status_now;
        wire logic [15:0] src_cnt;
        wire logic cnt_rd;
        wire logic advance;

        assign port_hit = reg_addr == port_ofs(i);
        assign data_wr = reg_wr && port_hit;
        assign data_rd[i] = reg_rd && port_hit;
        assign acc = ctrl_ff[`CDP_CTRL_HI:`CDP_ACC_LO];

        // a command naming this counter with a byte access mode
        assign mode_wr = cmd_wr && (cmd_sel == sel_code(i)) && (cmd_acc != `CDP_ACC_LATCH);

        // later captures are dropped while earlier ones wait to be read
        assign cnt_cap = cmd_wr && !cnt_held_ff
            && (((cmd_sel == sel_code(i)) && (cmd_acc == `CDP_ACC_LATCH))
            || (cmd_readback && !reg_wdata[`CDP_RB_NCOUNT_BIT] && rb_pick(reg_wdata, i)));
        assign st_cap = cmd_wr && !st_held_ff && cmd_readback
            && !reg_wdata[`CDP_RB_NSTATUS_BIT] && rb_pick(reg_wdata, i);

        // byte selection shared by reads and writes
        assign take_high = (acc == `CDP_ACC_HIGH)
            || ((acc == `CDP_ACC_BOTH) && (ptr_ff == counter_data_ports_pkg::PTR_HIGH));
        assign last_byte = (acc != `CDP_ACC_BOTH) || (ptr_ff == counter_data_ports_pkg::PTR_HIGH);

        assign status_now = {out_in[i], null_in[i], ctrl_ff};
        assign src_cnt = cnt_held_ff ? hold_cnt_ff : live_in[i];
        // status goes out ahead of any held count and uses no byte slot
        assign rd_byte[i] = st_held_ff ? hold_st_ff
            : (take_high ? src_cnt[15:8] : src_cnt[7:0]);
        assign cnt_rd = data_rd[i] && !st_held_ff;
        assign advance = (data_wr || cnt_rd) && (acc == `CDP_ACC_BOTH);

        always_comb begin
            nxt_ctrl = ctrl_ff;
            nxt_ptr = ptr_ff;
            nxt_hold_cnt = hold_cnt_ff;
            nxt_hold_st = hold_st_ff;
            nxt_low_buf = low_buf_ff;
            nxt_load = load_ff;
            nxt_cnt_held = cnt_held_ff;
            nxt_st_held = st_held_ff;
            nxt_load_pulse = 1'b0;
            if (mode_wr) begin
                nxt_ctrl = reg_wdata[`CDP_CTRL_HI:0];
                nxt_ptr = counter_data_ports_pkg::PTR_LOW;
            end else if (advance) begin
                nxt_ptr = (ptr_ff == counter_data_ports_pkg::PTR_LOW)
                    ? counter_data_ports_pkg::PTR_HIGH : counter_data_ports_pkg::PTR_LOW;
            end
            if (data_wr) begin
                unique case (acc)
                    `CDP_ACC_LOW: nxt_load = {8'h00, reg_wdata};
                    `CDP_ACC_HIGH: nxt_load = {reg_wdata, 8'h00};
                    default: begin
                        if (take_high) begin
                            nxt_load = {reg_wdata, low_buf_ff};
                        end else begin
                            nxt_low_buf = reg_wdata;
                        end
                    end
                endcase
                nxt_load_pulse = last_byte;
            end
            // held values only leave when read, counting does not touch them
            if (cnt_rd && cnt_held_ff && last_byte) begin
                nxt_cnt_held = 1'b0;
            end
            if (data_rd[i] && st_held_ff) begin
                nxt_st_held = 1'b0;
            end
            if (cnt_cap) begin
                nxt_hold_cnt = live_in[i];
                nxt_cnt_held = 1'b1;
            end
            if (st_cap) begin
                nxt_hold_st = status_now;
                nxt_st_held = 1'b1;
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                ctrl_ff <= `CDP_CTRL_RST;
                ptr_ff <= counter_data_ports_pkg::PTR_LOW;
                hold_cnt_ff <= `CDP_COUNT_RST;
                hold_st_ff <= `CDP_BYTE_RST;
                low_buf_ff <= `CDP_BYTE_RST;
                load_ff <= `CDP_COUNT_RST;
                cnt_held_ff <= 1'b0;
                st_held_ff <= 1'b0;
                load_pulse_ff <= 1'b0;
            end else begin
                ctrl_ff <= nxt_ctrl;
                ptr_ff <= nxt_ptr;
                hold_cnt_ff <= nxt_hold_cnt;
                hold_st_ff <= nxt_hold_st;
                low_buf_ff <= nxt_low_buf;
                load_ff <= nxt_load;
                cnt_held_ff <= nxt_cnt_held;
                st_held_ff <= nxt_st_held;
                load_pulse_ff <= nxt_load_pulse;
            end
        end
    end

    assign count_one_load_value = gen_cnt[0].load_ff;
    assign count_one_load_pulse = gen_cnt[0].load_pulse_ff;
    assign count_one_ctrl = gen_cnt[0].ctrl_ff;
    assign count_two_load_value = gen_cnt[1].load_ff;
    assign count_two_load_pulse = gen_cnt[1].load_pulse_ff;
    assign count_two_ctrl = gen_cnt[1].ctrl_ff;

    logic [7:0] rdata_ff;
    wire logic [7:0] nxt_rdata;

    // read data stands for one cycle only, other addresses read zero
    assign nxt_rdata = data_rd[0] ? rd_byte[0] : (data_rd[1] ? rd_byte[1] : `CDP_BYTE_RST);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `CDP_BYTE_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* File: verification/counter_data_ports_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module counter_data_ports_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] count_one_load_value,
    input wire logic count_one_load_pulse,
    input wire logic [5:0] count_one_ctrl,
    input wire logic [15:0] count_two_load_value,
    input wire logic count_two_load_pulse,
    input wire logic [5:0] count_two_ctrl
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr != 8'h18 && reg_addr != 8'h1a |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ONE_LOAD_CAUSE: assert property (count_one_load_pulse |-> $past(reg_wr) && $past(reg_addr) == 8'h18)
        else $error("counter one load without write");
    AST_TWO_LOAD_CAUSE: assert property (count_two_load_pulse |-> $past(reg_wr) && $past(reg_addr) == 8'h1a)
        else $error("counter two load without write");
    AST_ONE_VALUE_HELD: assert property ($changed(count_one_load_value) |-> count_one_load_pulse)
        else $error("load value moved without pulse");
    AST_ONE_CTRL_CAUSE: assert property ($changed(count_one_ctrl) |-> $past(reg_wr)
        && $past(reg_addr) == 8'h1e && $past(reg_wdata[7:6]) == 2'h0)
        else $error("counter one command from wrong select");
    AST_TWO_CTRL_CAUSE: assert property ($changed(count_two_ctrl) |-> $past(reg_wr)
        && $past(reg_addr) == 8'h1e && $past(reg_wdata[7:6]) == 2'h1)
        else $error("counter two command from wrong select");
    AST_ONE_CTRL_LOAD: assert property (reg_wr && reg_addr == 8'h1e && reg_wdata[7:4] == 4'h3
        |=> count_one_ctrl == $past(reg_wdata[5:0]))
        else $error("command not stored");
    AST_TWO_LOW_ONLY: assert property (reg_wr && reg_addr == 8'h1a && count_two_ctrl[5:4] == 2'h1
        |=> count_two_load_pulse && count_two_load_value == {8'h00, $past(reg_wdata)})
        else $error("low byte load wrong");
    AST_ONE_HIGH_ONLY: assert property (reg_wr && reg_addr == 8'h18 && count_one_ctrl[5:4] == 2'h2
        |=> count_one_load_pulse && count_one_load_value == {$past(reg_wdata), 8'h00})
        else $error("high byte load wrong");
endmodule
bind counter_data_ports counter_data_ports_checker chk_i (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_one_load_value(count_one_load_value), .count_one_load_pulse(count_one_load_pulse),
    .count_one_ctrl(count_one_ctrl), .count_two_load_value(count_two_load_value),
    .count_two_load_pulse(count_two_load_pulse), .count_two_ctrl(count_two_ctrl));
`default_nettype wire

/* File: verification/counter_data_ports_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module counter_data_ports_tb_top;
    logic core_clk, resetn, reg_wr, reg_rd, count_one_out, count_one_null, count_two_out, count_two_null;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_byte, port, b;
    logic [15:0] count_one_live, count_two_live, count_one_load_value, count_two_load_value, v, e, f;
    logic count_one_load_pulse, count_two_load_pulse, o, n;
    logic [5:0] count_one_ctrl, count_two_ctrl;
    logic [1:0] sel;
    int fail_count = 0;
    int checks_done = 0;
    counter_data_ports dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_one_live(count_one_live),
        .count_one_out(count_one_out), .count_one_null(count_one_null), .count_one_load_value(count_one_load_value),
        .count_one_load_pulse(count_one_load_pulse), .count_one_ctrl(count_one_ctrl),
        .count_two_live(count_two_live), .count_two_out(count_two_out), .count_two_null(count_two_null),
        .count_two_load_value(count_two_load_value), .count_two_load_pulse(count_two_load_pulse),
        .count_two_ctrl(count_two_ctrl));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // counter two always sees the inverse, so a swapped port shows up
    function automatic logic [15:0] live_of(input int i, input logic [15:0] x);
        return (i == 1) ? ~x : x;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_byte = reg_rdata;
    endtask
    task automatic set_live(input logic [15:0] x, input logic so, input logic sn);
        @(posedge core_clk);
        count_one_live <= x;
        count_two_live <= ~x;
        {count_one_out, count_one_null, count_two_out, count_two_null} <= {so, sn, so, sn};
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {count_one_live, count_two_live, count_one_out, count_one_null, count_two_out, count_two_null} = '0;
        void'($urandom(13));
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(16'(count_one_ctrl), 16'h0030);
        for (int i = 0; i < 2; i++) begin
            port = i ? 8'h1a : 8'h18;
            sel = 2'(i);
            v = 16'($urandom);
            {o, n} = 2'($urandom);
            set_live(v, o, n);
            wr(8'h1e, {sel, 6'h30});
            wr(port, v[7:0]);
            wr(port, v[15:8]);
            chk(16'(i ? count_two_load_pulse : count_one_load_pulse), 16'h0001);
            chk(i ? count_two_load_value : count_one_load_value, v);
            e = live_of(i, v);
            f = live_of(i, ~v);
            rd(port);
            chk(16'(rd_byte), 16'(e[7:0]));
            rd(port);
            chk(16'(rd_byte), 16'(e[15:8]));
            wr(8'h1e, {sel, 6'h00});
            set_live(~v, o, n);
            wr(8'h1e, {sel, 6'h00});
            rd(port);
            chk(16'(rd_byte), 16'(e[7:0]));
            rd(port);
            chk(16'(rd_byte), 16'(e[15:8]));
            rd(port);
            chk(16'(rd_byte), 16'(f[7:0]));
            rd(port);
            chk(16'(rd_byte), 16'(f[15:8]));
            wr(8'h1e, {4'hc, 1'b0, sel[0], ~sel[0], 1'b0});
            set_live(v, ~o, ~n);
            wr(8'h1e, {4'hc, 1'b0, sel[0], ~sel[0], 1'b0});
            rd(port);
            chk(16'(rd_byte), {8'h00, o, n, 6'h30});
            rd(port);
            chk(16'(rd_byte), 16'(f[7:0]));
            rd(port);
            chk(16'(rd_byte), 16'(f[15:8]));
            for (int m = 1; m < 3; m++) begin
                wr(8'h1e, {sel, 2'(m), 4'h0});
                b = 8'($urandom);
                wr(port, b);
                chk(i ? count_two_load_value : count_one_load_value, m == 1 ? {8'h00, b} : {b, 8'h00});
            end
            // single-byte mode: status, then one count byte, then live again
            wr(8'h1e, {4'hc, 1'b0, sel[0], ~sel[0], 1'b0});
            set_live(~v, o, n);
            rd(port);
            chk(16'(rd_byte), {8'h00, ~o, ~n, 6'h20});
            rd(port);
            chk(16'(rd_byte), 16'(e[15:8]));
            rd(port);
            chk(16'(rd_byte), 16'(f[15:8]));
        end
        wr(8'h1e, 8'h80);
        chk(16'(count_one_ctrl), 16'h0020);
        chk(16'(count_two_ctrl), 16'h0020);
        rd(8'h10);
        chk(16'(rd_byte), 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
